// >>> hw/fault_delay_timer.sv
// Restartable cycle counter that reports when a programmed count is reached.
`timescale 1ns/1ns
`include "fault_supervisor_consts.svh"

module fault_delay_timer (
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire logic                run,
   input  wire logic [`CNT_W-1:0]   limit,
   output logic                     expired
);

   typedef struct packed {
      logic [`CNT_W-1:0] count;
      logic              done;
   } timer_t;

   timer_t r;
   timer_t next_r;

   // ----------------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------------
   // Dropping run clears the count, so a condition that vanishes early restarts.
   always_comb begin
      next_r = r;
      if (!run) begin
         next_r.count = '0;
         next_r.done  = 1'b0;
      end else if (!r.done) begin
         if (r.count >= limit - `CNT_W'(1)) begin
            next_r.done = 1'b1;
         end else begin
            next_r.count = r.count + `CNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign expired = r.done;

endmodule

// >>> hw/fault_supervisor_consts.svh
// Timing, threshold, supply and width constants for the valve fault supervisor.
`ifndef FAULT_SUPERVISOR_CONSTS_SVH
`define FAULT_SUPERVISOR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_HZ          125000000
`define ACTIVE_DELAY_MS      500
`define ALT_DELAY_MS         750
`define PASSIVE_DELAY_MS     250
`define MIN_ALARM_MS         100
`define MS_TO_CYCLES(ms)     ((ms) * (`CLK_FREQ_HZ / 1000))

// ----------------------------------------------------------------------------
// Thresholds in percent
// ----------------------------------------------------------------------------
`define INPUT_LOW_PCT        15
`define INPUT_HIGH_PCT       85
`define LOOP_ERR_PCT         12
`define ALT_LOOP_ERR_PCT     25
`define PCT_FULL             100

// ----------------------------------------------------------------------------
// Supply supervision in millivolts
// ----------------------------------------------------------------------------
`define SUPPLY_HIGH_MV       36000
`define SUPPLY_LOW_MV        8500

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define VOLT_W               16
`define POS_W                12
`define CNT_W                27

`endif

// >>> hw/fault_supervisor_pkg.sv
// Types shared by the valve fault supervisor design files.
package fault_supervisor_pkg;

   typedef enum logic [1:0] {
      mon_idle,
      mon_delay,
      mon_alarm,
      mon_latched
   } mon_state_t;

endpackage

// >>> hw/valve_actuator_fault_supervisor.sv
// Fault supervisor and position loop gate for a proportional valve actuator.
`timescale 1ns/1ns
`include "fault_supervisor_consts.svh"

module valve_actuator_fault_supervisor
   import fault_supervisor_pkg::*;
#(
   parameter bit            ACTIVE_MODE              = 1'b1,
   parameter bit            ALTERNATE_ACTUATOR_VARIANT = 1'b0,
   parameter int            ACTIVE_DELAY_CYCLES      = `MS_TO_CYCLES(`ACTIVE_DELAY_MS),
   parameter int            ALT_DELAY_CYCLES         = `MS_TO_CYCLES(`ALT_DELAY_MS),
   parameter int            PASSIVE_DELAY_CYCLES     = `MS_TO_CYCLES(`PASSIVE_DELAY_MS),
   parameter int            MIN_ALARM_CYCLES         = `MS_TO_CYCLES(`MIN_ALARM_MS)
)(
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire logic [`VOLT_W-1:0]  setpoint_mv,
   input  wire logic [`VOLT_W-1:0]  supply_voltage_level,
   input  wire logic                transducer_open,
   input  wire logic                transducer_short,
   input  wire logic [`POS_W-1:0]   demand_pos,
   input  wire logic [`POS_W-1:0]   spool_pos,
   input  wire logic                clock_fail,
   output logic                     bridge_enable,
   output logic                     drive_a,
   output logic                     drive_b,
   output logic                     pwm_hold,
   output logic                     alarm,
   output logic                     input_error,
   output logic                     transducer_error,
   output logic                     loop_error,
   output logic                     supply_fault
);

   // ----------------------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------------------
   localparam int NEUTRAL = 1 << (`POS_W - 1);
   localparam int LOOP_PCT = ALTERNATE_ACTUATOR_VARIANT ? `ALT_LOOP_ERR_PCT : `LOOP_ERR_PCT;
   localparam int LOOP_LIMIT = (NEUTRAL * LOOP_PCT) / `PCT_FULL;
   // The alternate variant uses the longer delay in both handling modes.
   localparam int FAULT_DELAY = ALTERNATE_ACTUATOR_VARIANT ? ALT_DELAY_CYCLES :
                                (ACTIVE_MODE ? ACTIVE_DELAY_CYCLES : PASSIVE_DELAY_CYCLES);

   typedef struct packed {
      mon_state_t state;
      logic       input_err;
      logic       trans_err;
      logic       loop_err;
      logic       sup_fault;
      logic       alarm;
      logic       bridge;
      logic       drv_a;
      logic       drv_b;
      logic       hold;
   } sup_t;

   sup_t r;
   sup_t next_r;

   // ----------------------------------------------------------------------------
   // Error detection
   // ----------------------------------------------------------------------------
   // Products are widened so that a full-scale supply cannot overflow the compare.
   logic [`VOLT_W+7:0] sp_scaled;
   logic [`VOLT_W+7:0] lo_bound;
   logic [`VOLT_W+7:0] hi_bound;
   logic               in_err_now;
   logic               tr_err_now;
   logic               lp_err_now;
   logic               sup_bad_now;
   logic               any_err;
   logic signed [`POS_W:0] dem_off;
   logic signed [`POS_W:0] pos_off;
   logic [`POS_W:0]    dem_mag;
   logic [`POS_W:0]    pos_mag;
   logic               same_side;

   always_comb begin
      sp_scaled = (`VOLT_W+8)'(setpoint_mv) * (`VOLT_W+8)'(`PCT_FULL);
      lo_bound  = (`VOLT_W+8)'(supply_voltage_level) * (`VOLT_W+8)'(`INPUT_LOW_PCT);
      hi_bound  = (`VOLT_W+8)'(supply_voltage_level) * (`VOLT_W+8)'(`INPUT_HIGH_PCT);
      in_err_now = (sp_scaled < lo_bound) || (sp_scaled > hi_bound);
      tr_err_now = transducer_open || transducer_short;
      dem_off = $signed({1'b0, demand_pos}) - $signed((`POS_W+1)'(NEUTRAL));
      pos_off = $signed({1'b0, spool_pos}) - $signed((`POS_W+1)'(NEUTRAL));
      dem_mag = dem_off[`POS_W] ? (`POS_W+1)'(-dem_off) : (`POS_W+1)'(dem_off);
      pos_mag = pos_off[`POS_W] ? (`POS_W+1)'(-pos_off) : (`POS_W+1)'(pos_off);
      same_side = (dem_off[`POS_W] == pos_off[`POS_W]) || (pos_mag == '0);
      // On the demand's side only overshoot away from neutral counts, lagging toward neutral is in control; across neutral the whole gap counts.
      if (same_side) begin
         lp_err_now = (pos_mag > dem_mag) &&
                      ((pos_mag - dem_mag) > (`POS_W+1)'(LOOP_LIMIT));
      end else begin
         lp_err_now = (pos_mag + dem_mag) > (`POS_W+1)'(LOOP_LIMIT);
      end
      sup_bad_now = (supply_voltage_level > `VOLT_W'(`SUPPLY_HIGH_MV)) ||
                    (supply_voltage_level < `VOLT_W'(`SUPPLY_LOW_MV)) ||
                    clock_fail;
      // Supply and clock problems stay out of the alarm path.
      any_err = in_err_now || tr_err_now || lp_err_now;
   end

   // ----------------------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------------------
   logic delay_done;
   logic min_done;

   fault_delay_timer u_delay (
      .core_clk (core_clk),
      .rstn     (rstn),
      .run      (any_err && (r.state == mon_idle || r.state == mon_delay)),
      .limit    (`CNT_W'(FAULT_DELAY)),
      .expired  (delay_done)
   );

   fault_delay_timer u_min_alarm (
      .core_clk (core_clk),
      .rstn     (rstn),
      .run      (r.state == mon_alarm),
      .limit    (`CNT_W'(MIN_ALARM_CYCLES)),
      .expired  (min_done)
   );

   // ----------------------------------------------------------------------------
   // Monitor and drive
   // ----------------------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.input_err = in_err_now;
      next_r.trans_err = tr_err_now;
      next_r.loop_err  = lp_err_now;
      next_r.sup_fault = sup_bad_now;
      case (r.state)
         mon_idle: begin
            if (any_err) begin
               next_r.state = mon_delay;
            end
         end
         mon_delay: begin
            if (!any_err) begin
               next_r.state = mon_idle;
            end else if (delay_done) begin
               next_r.state = ACTIVE_MODE ? mon_latched : mon_alarm;
            end
         end
         mon_alarm: begin
            if (!any_err && min_done) begin
               next_r.state = mon_idle;
            end
         end
         mon_latched: begin
            // Only the power-up reset leaves this state.
            next_r.state = mon_latched;
         end
         default: begin
            next_r.state = mon_idle;
         end
      endcase
      next_r.alarm  = (next_r.state == mon_alarm) || (next_r.state == mon_latched);
      // Passive alarm leaves the bridge running.
      next_r.bridge = (next_r.state != mon_latched) && !sup_bad_now;
      next_r.hold   = (spool_pos == demand_pos);
      if (!next_r.bridge || next_r.hold) begin
         next_r.drv_a = 1'b0;
         next_r.drv_b = 1'b0;
      end else begin
         next_r.drv_a = demand_pos > spool_pos;
         next_r.drv_b = demand_pos < spool_pos;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         r <= '{state: mon_idle, default: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign bridge_enable    = r.bridge;
   assign drive_a          = r.drv_a;
   assign drive_b          = r.drv_b;
   assign pwm_hold         = r.hold;
   assign alarm            = r.alarm;
   assign input_error      = r.input_err;
   assign transducer_error = r.trans_err;
   assign loop_error       = r.loop_err;
   assign supply_fault     = r.sup_fault;

endmodule

// >>> testbench/spool_model.sv
// Spool stand-in that follows the solenoid drives.
`timescale 1ns/1ns
`include "fault_supervisor_consts.svh"
module spool_model (
   input  wire logic              core_clk,
   input  wire logic              jam,
   input  wire logic [`POS_W-1:0] jam_pos,
   input  wire logic              drive_a,
   input  wire logic              drive_b,
   output logic      [`POS_W-1:0] spool_pos
);
   // A jammed spool stands for a stuck valve, so loop errors can be forced.
   always_ff @(posedge core_clk) begin
      if (jam) begin
         spool_pos <= jam_pos;
      end else if (drive_a && !drive_b) begin
         spool_pos <= spool_pos + 12'h001;
      end else if (drive_b && !drive_a) begin
         spool_pos <= spool_pos - 12'h001;
      end
   end
endmodule

// >>> testbench/valve_actuator_fault_supervisor_tb.sv
// Self-checking bench for the valve fault supervisor.
`timescale 1ns/1ns
module valve_actuator_fault_supervisor_tb;
   typedef struct packed {
      logic [15:0] sp; logic [15:0] sup; logic op; logic sh;
      logic [11:0] dem; logic [11:0] pos; logic cf; logic [4:0] ex;
   } row_t;
   // Expected bits: input, transducer, loop, supply fault, bridge.
   row_t rows [16] = '{
      '{16'h2EE0,16'h5DC0,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h01},
      '{16'h0E0F,16'h5DC0,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h11},
      '{16'h0E10,16'h5DC0,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h01},
      '{16'h4FB0,16'h5DC0,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h01},
      '{16'h4FB1,16'h5DC0,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h11},
      '{16'h2EE0,16'h5DC0,1'b1,1'b0,12'h9F4,12'h9F4,1'b0,5'h09},
      '{16'h2EE0,16'h5DC0,1'b0,1'b1,12'h9F4,12'h9F4,1'b0,5'h09},
      '{16'h2EE0,16'h5DC0,1'b0,1'b0,12'h9F4,12'hAE9,1'b0,5'h01},
      '{16'h2EE0,16'h5DC0,1'b0,1'b0,12'h9F4,12'hAEA,1'b0,5'h05},
      '{16'h2EE0,16'h5DC0,1'b0,1'b0,12'h9F4,12'h834,1'b0,5'h01},
      '{16'h2EE0,16'h5DC0,1'b0,1'b0,12'h864,12'h738,1'b0,5'h05},
      '{16'h2EE0,16'h8CA0,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h01},
      '{16'h2EE0,16'h8CA1,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h02},
      '{16'h109A,16'h2134,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h01},
      '{16'h109A,16'h2133,1'b0,1'b0,12'h9F4,12'h9F4,1'b0,5'h02},
      '{16'h2EE0,16'h5DC0,1'b0,1'b0,12'h9F4,12'h9F4,1'b1,5'h02}};
   // Short delays keep the run small; the ratios between them follow the real ones.
   localparam int ACT_CYC = 20;
   localparam int PAS_CYC = 10;
   localparam int MIN_CYC = 4;
   logic        core_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [15:0] sp = 16'h2EE0;
   logic [15:0] sup = 16'h5DC0;
   logic        op = 1'b0;
   logic        sh = 1'b0;
   logic        cf = 1'b0;
   logic        jam = 1'b1;
   logic [11:0] dem = 12'h9F4;
   logic [11:0] jpos = 12'h9F4;
   logic [11:0] pos;
   logic [8:0]  ao;
   logic [8:0]  po;
   int          err_total = 0;
   int          compares = 0;
   int          cycles = 0;
   always #4 core_clk = ~core_clk;
   valve_actuator_fault_supervisor #(.ACTIVE_MODE(1'b1), .ACTIVE_DELAY_CYCLES(ACT_CYC),
      .PASSIVE_DELAY_CYCLES(PAS_CYC), .MIN_ALARM_CYCLES(MIN_CYC))
   i_valve_actuator_fault_supervisor (.core_clk(core_clk), .rstn(rstn), .setpoint_mv(sp),
      .supply_voltage_level(sup), .transducer_open(op), .transducer_short(sh),
      .demand_pos(dem), .spool_pos(pos), .clock_fail(cf), .input_error(ao[8]),
      .transducer_error(ao[7]), .loop_error(ao[6]), .supply_fault(ao[5]),
      .bridge_enable(ao[4]), .alarm(ao[3]), .pwm_hold(ao[2]), .drive_a(ao[1]), .drive_b(ao[0]));
   valve_actuator_fault_supervisor #(.ACTIVE_MODE(1'b0), .ACTIVE_DELAY_CYCLES(ACT_CYC),
      .PASSIVE_DELAY_CYCLES(PAS_CYC), .MIN_ALARM_CYCLES(MIN_CYC))
   i_valve_actuator_fault_supervisor_passive (.core_clk(core_clk), .rstn(rstn),
      .setpoint_mv(sp), .supply_voltage_level(sup), .transducer_open(op),
      .transducer_short(sh), .demand_pos(dem), .spool_pos(pos), .clock_fail(cf),
      .input_error(po[8]), .transducer_error(po[7]), .loop_error(po[6]), .supply_fault(po[5]),
      .bridge_enable(po[4]), .alarm(po[3]), .pwm_hold(po[2]), .drive_a(po[1]), .drive_b(po[0]));
   spool_model i_spool_model (.core_clk(core_clk), .jam(jam), .jam_pos(jpos),
      .drive_a(ao[1]), .drive_b(ao[0]), .spool_pos(pos));
   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apply(input row_t r);
      {sp, sup, op, sh, dem, jpos, cf} = {r.sp, r.sup, r.op, r.sh, r.dem, r.pos, r.cf};
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic results();
      $display("Compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // A hang is cut short well beyond the few hundred cycles the run needs.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         results();
      end
   end
   initial begin
      step(2);
      rstn = 1'b1;
      step(2);
      for (int i = 0; i < 16; i++) begin
         apply(rows[i]);
         step(2);
         chk("flags_active", rows[i].ex, ao[8:4]);
         chk("flags_passive", rows[i].ex, po[8:4]);
         apply(rows[0]);
         step(2);
      end
      apply(rows[8]);
      step(8);
      apply(rows[0]);
      step(3);
      apply(rows[8]);
      step(8);
      chk("alarms_restart", 5'h00, {ao[3], po[3]});
      step(8);
      chk("passive_alarm_bridge", 5'h03, {ao[3], po[3], po[4]});
      step(10);
      chk("active_trip", 5'h04, {ao[4:3], ao[1:0]});
      apply(rows[0]);
      step(10);
      chk("latched_vs_cleared", 5'h02, {ao[4:3], po[3]});
      apply(rows[8]);
      for (int n = 0; n < 40 && po[3] !== 1'b1; n++) step(1);
      apply(rows[0]);
      step(3);
      chk("alarm_minimum", 5'h01, po[3]);
      step(8);
      chk("alarm_release", 5'h00, po[3]);
      rstn = 1'b0;
      step(2);
      rstn = 1'b1;
      step(3);
      chk("after_power_cycle", 5'h02, ao[4:3]);
      jpos = 12'h800;
      step(1);
      jam = 1'b0;
      step(3);
      chk("drive_toward_demand", 5'h02, ao[1:0]);
      for (int n = 0; n < 600 && ao[2] !== 1'b1; n++) step(1);
      chk("hold_at_demand", 5'h04, ao[2:0]);
      jam = 1'b1;
      results();
   end
endmodule

// >>> testbench/valve_supervisor_assertions.sv
// Port-level checks for the valve fault supervisor.
`timescale 1ns/1ns
`include "fault_supervisor_consts.svh"
module valve_supervisor_checker #(
   parameter bit ACTIVE_MODE = 1'b1
)(
   input wire logic                core_clk,
   input wire logic                rstn,
   input wire logic [`VOLT_W-1:0]  setpoint_mv,
   input wire logic [`VOLT_W-1:0]  supply_voltage_level,
   input wire logic                transducer_open,
   input wire logic                transducer_short,
   input wire logic [`POS_W-1:0]   demand_pos,
   input wire logic [`POS_W-1:0]   spool_pos,
   input wire logic                clock_fail,
   input wire logic                bridge_enable,
   input wire logic                drive_a,
   input wire logic                drive_b,
   input wire logic                pwm_hold,
   input wire logic                alarm,
   input wire logic                input_error,
   input wire logic                transducer_error,
   input wire logic                loop_error,
   input wire logic                supply_fault
);
   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire logic hi_sup = supply_voltage_level > `SUPPLY_HIGH_MV;
   wire logic lo_sup = supply_voltage_level < `SUPPLY_LOW_MV;
   wire logic in_bad = setpoint_mv * 100 < `INPUT_LOW_PCT * supply_voltage_level ||
                       setpoint_mv * 100 > `INPUT_HIGH_PCT * supply_voltage_level;
   wire logic err_any = input_error || transducer_error || loop_error;
   AST_SUPPLY_HIGH: assert property (hi_sup |=> !bridge_enable && !drive_a && !drive_b)
      else $error("Bridge live on high supply.");
   AST_SUPPLY_LOW: assert property (lo_sup |=> !bridge_enable && !drive_a && !drive_b)
      else $error("Bridge live on low supply.");
   AST_CLOCK_FAIL: assert property (clock_fail |=> !bridge_enable && !drive_a)
      else $error("Bridge live on clock failure.");
   AST_INPUT_RANGE: assert property (rstn && $past(rstn) && in_bad |=> input_error)
      else $error("Set-point out of range not flagged.");
   AST_WIRE: assert property ($past(rstn) && (transducer_open || transducer_short)
      |=> transducer_error) else $error("Transducer wire fault not flagged.");
   AST_ALARM_CAUSE: assert property ($rose(alarm) |-> $past(err_any) && $past(err_any, 8))
      else $error("Alarm without a lasting monitored error.");
   AST_LATCH: assert property (ACTIVE_MODE && alarm |=> alarm && !bridge_enable)
      else $error("Active fault state left its latch.");
   AST_PASSIVE_BRIDGE: assert property (!ACTIVE_MODE && alarm && !hi_sup && !lo_sup
      && !clock_fail |=> bridge_enable) else $error("Passive alarm dropped the bridge.");
   AST_MIN_ALARM: assert property (!ACTIVE_MODE && $rose(alarm) |-> alarm [*4])
      else $error("Passive alarm shorter than its minimum.");
endmodule
bind valve_actuator_fault_supervisor valve_supervisor_checker #(.ACTIVE_MODE(ACTIVE_MODE))
   i_valve_supervisor_checker (.core_clk(core_clk), .rstn(rstn), .setpoint_mv(setpoint_mv),
   .supply_voltage_level(supply_voltage_level), .transducer_open(transducer_open),
   .transducer_short(transducer_short), .demand_pos(demand_pos), .spool_pos(spool_pos),
   .clock_fail(clock_fail), .bridge_enable(bridge_enable), .drive_a(drive_a),
   .drive_b(drive_b), .pwm_hold(pwm_hold), .alarm(alarm), .input_error(input_error),
   .transducer_error(transducer_error), .loop_error(loop_error), .supply_fault(supply_fault));
